// >>> include/jpd_pkg.sv
// Shared constants and types for the scan-port programming data path
package jpd_pkg;

	// ------------------------------------------------------------
	// Instruction register
	// ------------------------------------------------------------
	localparam int IR_W = 4;
	localparam logic [3:0] IR_HOLD_RESET = 4'hc;
	localparam logic [3:0] IR_UNLOCK = 4'h4;
	localparam logic [3:0] IR_COMMAND = 4'h5;
	localparam logic [3:0] IR_PAGE_LOAD = 4'h6;
	localparam logic [3:0] IR_PAGE_READ = 4'h7;
	localparam logic [3:0] IR_BYPASS = 4'hf;
	localparam logic [3:0] IR_CAPTURE_VAL = 4'h1;

	// ------------------------------------------------------------
	// Data registers
	// ------------------------------------------------------------
	localparam int UNLOCK_W = 16;
	localparam logic [15:0] UNLOCK_SIG = 16'ha370;
	localparam logic [15:0] UNLOCK_RST = 16'h0000;
	localparam int CMD_W = 15;
	localparam int BYTE_W = 8;
	localparam int ADDR_W = 8;
	localparam int PAGE_BYTES_DEF = 256;

	// Upper seven command bits that matter for byte ordering
	localparam logic [6:0] OP_LOAD_DATA_LO = 7'h13;
	localparam logic [6:0] OP_LOAD_DATA_HI = 7'h17;
	localparam logic [6:0] OP_LOAD_ADDR_LO = 7'h03;

	// ------------------------------------------------------------
	// Register port map
	// ------------------------------------------------------------
	localparam logic [7:0] CCSR_ADDR = 8'h00;
	localparam logic [7:0] STAT_ADDR = 8'h01;
	localparam int CCSR_DISABLE_BIT = 7;
	localparam logic CCSR_DISABLE_RST = 1'b0;
	localparam int STAT_PROG_BIT = 0;
	localparam int STAT_CORE_RST_BIT = 1;
	localparam int STAT_ORDER_ERR_BIT = 2;
	localparam int STAT_ACCESS_BIT = 3;
	localparam int STAT_IR_LSB = 4;

	// ------------------------------------------------------------
	// Timing
	// ------------------------------------------------------------
	localparam int CLK_HZ = 10_000_000;
	localparam logic [1:0] DISABLE_CLR_CLKS = 2'h2;
	localparam int RESET_TIMEOUT_DEF = 16;

	// ------------------------------------------------------------
	// Scan controller states
	// ------------------------------------------------------------
	typedef enum logic [3:0] {
		TAP_RESET = 4'b0000,
		TAP_IDLE = 4'b0001,
		TAP_SEL_DR = 4'b0010,
		TAP_CAP_DR = 4'b0011,
		TAP_SH_DR = 4'b0100,
		TAP_EX1_DR = 4'b0101,
		TAP_PAU_DR = 4'b0110,
		TAP_EX2_DR = 4'b0111,
		TAP_UPD_DR = 4'b1000,
		TAP_SEL_IR = 4'b1001,
		TAP_CAP_IR = 4'b1010,
		TAP_SH_IR = 4'b1011,
		TAP_EX1_IR = 4'b1100,
		TAP_PAU_IR = 4'b1101,
		TAP_EX2_IR = 4'b1110,
		TAP_UPD_IR = 4'b1111
	} jpd_tap_t;

endpackage

// >>> include/jpd_mem_if.sv
// Page buffer access between the scan logic and the page memory
`timescale 1ns/1ns
interface jpd_mem_if;
	import jpd_pkg::*;
	logic we;
	logic [ADDR_W-1:0] waddr;
	logic [BYTE_W-1:0] wdata;
	logic [ADDR_W-1:0] raddr;
	logic [BYTE_W-1:0] rdata;
	modport ctrl (output we, output waddr, output wdata, output raddr, input rdata);
	modport mem (input we, input waddr, input wdata, input raddr, output rdata);
endinterface

// >>> design/jpd_page_mem.sv
// Page buffer memory with registered read data
`timescale 1ns/1ns
module jpd_page_mem #(
	parameter int DEPTH = 256
) (
	input wire logic clk_i,
	input wire logic sys_rst_i,
	jpd_mem_if.mem bus
);
	import jpd_pkg::*;

	if (DEPTH < 1 || DEPTH > (1 << ADDR_W)) begin : g_bad_depth
		$error("DEPTH must be 1 to 256");
	end

	logic [BYTE_W-1:0] store [DEPTH];

	// Array has no reset so it maps onto plain RAM
	always_ff @(posedge clk_i) begin
		if (bus.we) begin
			store[bus.waddr] <= bus.wdata;
		end
	end

	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			bus.rdata <= 8'h00;
		end else begin
			bus.rdata <= store[bus.raddr];
		end
	end
endmodule

// >>> design/jpd_top.sv
// Scan-port programming data path: TAP, instruction and data registers
`timescale 1ns/1ns

module jpd_top #(
	parameter int PAGE_BYTES = jpd_pkg::PAGE_BYTES_DEF,
	parameter int RESET_TIMEOUT_CYC = jpd_pkg::RESET_TIMEOUT_DEF
) (
	input wire logic clk_i,
	input wire logic sys_rst_i,
	input wire logic tck_i,
	input wire logic tms_i,
	input wire logic tdi_i,
	output logic tdo_o,
	output logic tdo_oe_o,
	input wire logic scan_port_enable_fuse_i,
	input wire logic ext_reset_n_i,
	input wire logic [jpd_pkg::CMD_W-1:0] cmd_result_i,
	output logic [jpd_pkg::CMD_W-1:0] cmd_o,
	output logic cmd_apply_o,
	output logic cmd_exec_o,
	output logic core_reset_o,
	output logic prog_mode_o,
	input wire logic [jpd_pkg::ADDR_W-1:0] page_raddr_i,
	output logic [jpd_pkg::BYTE_W-1:0] page_rdata_o,
	input wire logic [7:0] reg_addr_i,
	input wire logic [7:0] reg_wdata_i,
	input wire logic reg_we_i,
	input wire logic reg_re_i,
	output logic [7:0] reg_rdata_o
);
	import jpd_pkg::*;

	// ------------------------------------------------------------
	// Parameter checks
	// ------------------------------------------------------------
	if (PAGE_BYTES < 2 || PAGE_BYTES > (1 << ADDR_W) || (PAGE_BYTES & (PAGE_BYTES - 1)) != 0) begin : g_bad_page
		$error("PAGE_BYTES must be a power of two from 2 to 256");
	end
	if (RESET_TIMEOUT_CYC < 1 || RESET_TIMEOUT_CYC > 65535) begin : g_bad_tmo
		$error("RESET_TIMEOUT_CYC must be 1 to 65535");
	end

	localparam logic [ADDR_W-1:0] LAST_BYTE = ADDR_W'(PAGE_BYTES - 1);
	localparam logic [15:0] TIMEOUT_LOAD = 16'(RESET_TIMEOUT_CYC);

	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	typedef struct packed {
		logic [1:0] tck_s;
		logic tck_d;
		logic [1:0] tms_s;
		logic [1:0] tdi_s;
		logic [1:0] fuse_s;
		logic [1:0] rstn_s;
		jpd_tap_t tap;
		logic [IR_W-1:0] ir;
		logic [IR_W-1:0] ir_sh;
		logic bypass;
		logic rst_chain;
		logic [UNLOCK_W-1:0] unlock;
		logic [CMD_W-1:0] cmd_sh;
		logic [CMD_W-1:0] cmd;
		logic cmd_apply;
		logic cmd_exec;
		logic low_ok;
		logic order_err;
		logic [BYTE_W-1:0] byte_sh;
		logic [2:0] bit_cnt;
		logic [ADDR_W-1:0] byte_addr;
		logic mem_we;
		logic [ADDR_W-1:0] mem_waddr;
		logic [BYTE_W-1:0] mem_wdata;
		logic disable_bit;
		logic [1:0] clr_cnt;
		logic [15:0] tmo_cnt;
		logic core_reset;
		logic prog_en;
		logic tdo;
		logic tdo_oe;
		logic [7:0] rdata;
	} jpd_state_t;

	jpd_state_t s;
	jpd_state_t next_s;

	jpd_mem_if page_bus ();

	jpd_page_mem #(
		.DEPTH(PAGE_BYTES)
	) u_page_mem (
		.clk_i(clk_i),
		.sys_rst_i(sys_rst_i),
		.bus(page_bus.mem)
	);

	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	function automatic jpd_tap_t tap_next(input jpd_tap_t st, input logic tms);
		jpd_tap_t r;
		r = st;
		unique case (st)
			TAP_RESET: r = tms ? TAP_RESET : TAP_IDLE;
			TAP_IDLE: r = tms ? TAP_SEL_DR : TAP_IDLE;
			TAP_SEL_DR: r = tms ? TAP_SEL_IR : TAP_CAP_DR;
			TAP_CAP_DR: r = tms ? TAP_EX1_DR : TAP_SH_DR;
			TAP_SH_DR: r = tms ? TAP_EX1_DR : TAP_SH_DR;
			TAP_EX1_DR: r = tms ? TAP_UPD_DR : TAP_PAU_DR;
			TAP_PAU_DR: r = tms ? TAP_EX2_DR : TAP_PAU_DR;
			TAP_EX2_DR: r = tms ? TAP_UPD_DR : TAP_SH_DR;
			TAP_UPD_DR: r = tms ? TAP_SEL_DR : TAP_IDLE;
			TAP_SEL_IR: r = tms ? TAP_RESET : TAP_CAP_IR;
			TAP_CAP_IR: r = tms ? TAP_EX1_IR : TAP_SH_IR;
			TAP_SH_IR: r = tms ? TAP_EX1_IR : TAP_SH_IR;
			TAP_EX1_IR: r = tms ? TAP_UPD_IR : TAP_PAU_IR;
			TAP_PAU_IR: r = tms ? TAP_EX2_IR : TAP_PAU_IR;
			TAP_EX2_IR: r = tms ? TAP_UPD_IR : TAP_SH_IR;
			TAP_UPD_IR: r = tms ? TAP_SEL_DR : TAP_IDLE;
		endcase
		return r;
	endfunction

	function automatic logic [ADDR_W-1:0] addr_step(input logic [ADDR_W-1:0] a);
		return (a == LAST_BYTE) ? '0 : ADDR_W'(a + 1'b1);
	endfunction

	// ------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------
	logic tck_rise;
	logic tck_fall;
	logic tms_q;
	logic tdi_q;
	logic access_ok;
	logic ext_low;
	logic [6:0] op;

	always_comb begin
		next_s = s;
		next_s.cmd_apply = 1'b0;
		next_s.mem_we = 1'b0;
		next_s.cmd_exec = 1'b0;

		// Pins pass two flops; only the second stage is read below
		next_s.tck_s = {s.tck_s[0], tck_i};
		next_s.tms_s = {s.tms_s[0], tms_i};
		next_s.tdi_s = {s.tdi_s[0], tdi_i};
		next_s.fuse_s = {s.fuse_s[0], scan_port_enable_fuse_i};
		next_s.rstn_s = {s.rstn_s[0], ext_reset_n_i};
		next_s.tck_d = s.tck_s[1];

		tck_rise = s.tck_s[1] & ~s.tck_d;
		tck_fall = ~s.tck_s[1] & s.tck_d;
		tms_q = s.tms_s[1];
		tdi_q = s.tdi_s[1];
		ext_low = ~s.rstn_s[1];
		access_ok = s.fuse_s[1] & ~s.disable_bit;
		op = s.cmd_sh[CMD_W-1 -: 7];

		// Reset pin low for two clocks clears the disable bit, handing the test pins back to the scan port
		if (s.disable_bit && ext_low) begin
			if (s.clr_cnt == DISABLE_CLR_CLKS - 2'h1) begin
				next_s.disable_bit = 1'b0;
				next_s.clr_cnt = 2'h0;
			end else begin
				next_s.clr_cnt = s.clr_cnt + 2'h1;
			end
		end else begin
			next_s.clr_cnt = 2'h0;
		end

		// Register port; a write to status with bit 2 set clears the ordering error
		if (reg_we_i && reg_addr_i == CCSR_ADDR) begin
			next_s.disable_bit = reg_wdata_i[CCSR_DISABLE_BIT];
		end
		if (reg_we_i && reg_addr_i == STAT_ADDR && reg_wdata_i[STAT_ORDER_ERR_BIT]) begin
			next_s.order_err = 1'b0;
		end

		if (!access_ok) begin
			// Locked out: controller parked, pin released
			next_s.tap = TAP_RESET;
			next_s.ir = IR_BYPASS;
			next_s.rst_chain = 1'b0;
			next_s.tdo_oe = 1'b0;
		end else if (tck_rise) begin
			unique case (s.tap)
				TAP_RESET: begin
					next_s.ir = IR_BYPASS;
					next_s.rst_chain = 1'b0;
				end
				TAP_IDLE: begin
					if (s.ir == IR_COMMAND && s.prog_en) begin
						next_s.cmd_exec = 1'b1;
					end
				end
				TAP_CAP_DR: begin
					unique case (s.ir)
						IR_COMMAND: next_s.cmd_sh = cmd_result_i;
						IR_PAGE_LOAD, IR_PAGE_READ: begin
							next_s.bit_cnt = 3'h0;
							next_s.byte_addr = '0;
							next_s.byte_sh = 8'h00;
						end
						IR_HOLD_RESET, IR_UNLOCK: ;
						default: next_s.bypass = 1'b0;
					endcase
				end
				TAP_SH_DR: begin
					// Every chain but page read takes TDI at the top (page read takes zero) and drops bit 0 to TDO
					unique case (s.ir)
						IR_HOLD_RESET: next_s.rst_chain = tdi_q;
						IR_UNLOCK: next_s.unlock = {tdi_q, s.unlock[UNLOCK_W-1:1]};
						IR_COMMAND: next_s.cmd_sh = {tdi_q, s.cmd_sh[CMD_W-1:1]};
						IR_PAGE_LOAD: begin
							next_s.byte_sh = {tdi_q, s.byte_sh[BYTE_W-1:1]};
							next_s.bit_cnt = s.bit_cnt + 3'h1;
							if (s.bit_cnt == 3'h7) begin
								next_s.mem_we = s.prog_en;
								next_s.mem_waddr = s.byte_addr;
								next_s.mem_wdata = {tdi_q, s.byte_sh[BYTE_W-1:1]};
								next_s.byte_addr = addr_step(s.byte_addr);
							end
						end
						IR_PAGE_READ: begin
							// First byte out is filler, giving the page plus eight
							next_s.bit_cnt = s.bit_cnt + 3'h1;
							if (s.bit_cnt == 3'h7) begin
								next_s.byte_sh = s.prog_en ? page_bus.rdata : 8'h00;
								next_s.byte_addr = addr_step(s.byte_addr);
							end else begin
								next_s.byte_sh = {1'b0, s.byte_sh[BYTE_W-1:1]};
							end
						end
						default: next_s.bypass = tdi_q;
					endcase
				end
				TAP_UPD_DR: begin
					if (s.ir == IR_COMMAND && s.prog_en) begin
						if (op == OP_LOAD_DATA_HI && !s.low_ok) begin
							next_s.order_err = 1'b1;
						end else begin
							next_s.cmd = s.cmd_sh;
							next_s.cmd_apply = 1'b1;
						end
						if (op == OP_LOAD_DATA_LO) begin
							next_s.low_ok = 1'b1;
						end else if (op == OP_LOAD_DATA_HI || op == OP_LOAD_ADDR_LO) begin
							next_s.low_ok = 1'b0;
						end
					end
				end
				TAP_CAP_IR: next_s.ir_sh = IR_CAPTURE_VAL;
				TAP_SH_IR: next_s.ir_sh = {tdi_q, s.ir_sh[IR_W-1:1]};
				TAP_UPD_IR: next_s.ir = s.ir_sh;
				TAP_SEL_DR, TAP_EX1_DR, TAP_PAU_DR, TAP_EX2_DR,
				TAP_SEL_IR, TAP_EX1_IR, TAP_PAU_IR, TAP_EX2_IR: ;
			endcase
			next_s.tap = tap_next(s.tap, tms_q);
		end else if (tck_fall) begin
			// Output changes on the falling test clock edge
			next_s.tdo_oe = (s.tap == TAP_SH_DR) || (s.tap == TAP_SH_IR);
			if (s.tap == TAP_SH_IR) begin
				next_s.tdo = s.ir_sh[0];
			end else begin
				unique case (s.ir)
					IR_HOLD_RESET: next_s.tdo = s.rst_chain;
					IR_UNLOCK: next_s.tdo = s.unlock[0];
					IR_COMMAND: next_s.tdo = s.cmd_sh[0];
					IR_PAGE_LOAD, IR_PAGE_READ: next_s.tdo = s.byte_sh[0];
					default: next_s.tdo = s.bypass;
				endcase
			end
		end

		// Chain value goes out in the same cycle it is shifted in
		if (ext_low || next_s.rst_chain) begin
			next_s.tmo_cnt = TIMEOUT_LOAD;
		end else if (s.tmo_cnt != 16'h0000) begin
			next_s.tmo_cnt = s.tmo_cnt - 16'h0001;
		end
		next_s.core_reset = ext_low || next_s.rst_chain || next_s.tmo_cnt != 16'h0000;

		// Entry only at Update-DR of the unlock chain; a later mismatch drops it at once
		next_s.prog_en = access_ok && next_s.unlock == UNLOCK_SIG
			&& (s.prog_en || (tck_rise && s.tap == TAP_UPD_DR && s.ir == IR_UNLOCK));

		next_s.rdata = 8'h00;
		if (reg_re_i) begin
			if (reg_addr_i == CCSR_ADDR) begin
				next_s.rdata[CCSR_DISABLE_BIT] = s.disable_bit;
			end else if (reg_addr_i == STAT_ADDR) begin
				next_s.rdata[STAT_PROG_BIT] = s.prog_en;
				next_s.rdata[STAT_CORE_RST_BIT] = s.core_reset;
				next_s.rdata[STAT_ORDER_ERR_BIT] = s.order_err;
				next_s.rdata[STAT_ACCESS_BIT] = access_ok;
				next_s.rdata[STAT_IR_LSB +: IR_W] = s.ir;
			end
		end
	end

	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			s <= '0;
			s.tck_s <= 2'h0;
			s.rstn_s <= 2'h3;
			s.tap <= TAP_RESET;
			s.ir <= IR_BYPASS;
			s.unlock <= UNLOCK_RST;
			s.disable_bit <= CCSR_DISABLE_RST;
		end else begin
			s <= next_s;
		end
	end

	// ------------------------------------------------------------
	// Page buffer hookup and outputs
	// ------------------------------------------------------------
	assign page_bus.we = s.mem_we;
	assign page_bus.waddr = s.mem_waddr;
	assign page_bus.wdata = s.mem_wdata;
	// Scan read owns the port only while the read instruction is loaded
	assign page_bus.raddr = (s.ir == IR_PAGE_READ) ? s.byte_addr : page_raddr_i;

	assign tdo_o = s.tdo;
	assign tdo_oe_o = s.tdo_oe;
	assign cmd_o = s.cmd;
	assign cmd_apply_o = s.cmd_apply;
	assign cmd_exec_o = s.cmd_exec;
	assign core_reset_o = s.core_reset;
	assign prog_mode_o = s.prog_en;
	assign page_rdata_o = page_bus.rdata;
	assign reg_rdata_o = s.rdata;
endmodule

// >>> tb/jpd_top_monitor.sv
// Port-level assertions for the scan-port programming data path
`timescale 1ns/1ns
module jpd_top_monitor
	import jpd_pkg::*;
(
	input wire logic clk_i,
	input wire logic sys_rst_i,
	input wire logic tck_i,
	input wire logic tdo_o,
	input wire logic tdo_oe_o,
	input wire logic scan_port_enable_fuse_i,
	input wire logic ext_reset_n_i,
	input wire logic [jpd_pkg::CMD_W-1:0] cmd_o,
	input wire logic cmd_apply_o,
	input wire logic cmd_exec_o,
	input wire logic core_reset_o,
	input wire logic prog_mode_o
);
	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (sys_rst_i);
	// Four samples cover the fuse synchroniser
	chk_fuse_blocks: assert property ((!scan_port_enable_fuse_i) [*4] |-> !tdo_oe_o)
		else $error("tdo enabled with fuse clear");
	chk_ext_core_reset: assert property ((!ext_reset_n_i) [*5] |-> core_reset_o)
		else $error("core not held during external reset");
	chk_tdo_after_fall: assert property ($changed(tdo_o) |-> !$past(tck_i, 2))
		else $error("tdo moved outside test clock low phase");
	chk_oe_after_fall: assert property ($rose(tdo_oe_o) |-> !$past(tck_i, 2) && scan_port_enable_fuse_i)
		else $error("tdo enable rose at wrong moment");
	chk_apply_one_pulse: assert property (cmd_apply_o |-> prog_mode_o ##1 !cmd_apply_o)
		else $error("command apply outside programming or too long");
	chk_cmd_held: assert property ($changed(cmd_o) |-> cmd_apply_o || $past(cmd_apply_o))
		else $error("command output moved without apply");
	chk_exec_on_tck: assert property (cmd_exec_o |-> prog_mode_o && $past(tck_i, 2))
		else $error("execute pulse without idle test clock");
	chk_prog_after_reset: assert property ($fell(sys_rst_i) |-> !prog_mode_o [*8])
		else $error("programming mode right after reset");
endmodule
bind jpd_top jpd_top_monitor u_mon (.clk_i, .sys_rst_i, .tck_i, .tdo_o, .tdo_oe_o, .scan_port_enable_fuse_i,
	.ext_reset_n_i, .cmd_o, .cmd_apply_o, .cmd_exec_o, .core_reset_o, .prog_mode_o);

// >>> tb/jpd_prog_model.sv
// Programmer model driving three test pins (tck, tms, tdi) and reading tdo
`timescale 1ns/1ns
module jpd_prog_model (
	input wire logic clk_i,
	input wire logic tdo_i,
	output logic tck_o,
	output logic tms_o,
	output logic tdi_o
);
	// ------------------------------------------------------------
	// Pin driver
	// ------------------------------------------------------------
	// Only the four test pins; the pins stay dedicated to the test port
	// Sole device on the chain, so bulk page modes are allowed
	initial begin
		tck_o = 1'b0;
		tms_o = 1'b1;
		tdi_o = 1'b0;
	end
	// Eight clocks a period; tck stands low between calls, tdo read at the fall
	task automatic tick(input logic m, input logic d, output logic q);
		@(posedge clk_i);
		tms_o <= m;
		tdi_o <= d;
		repeat (3) @(posedge clk_i);
		tck_o <= 1'b1;
		repeat (4) @(posedge clk_i);
		q = tdo_i;
		tck_o <= 1'b0;
	endtask
	task automatic start();
		logic q;
		repeat (5) tick(1'b1, ~tdi_o, q);
		tick(1'b0, ~tdi_o, q);
	endtask
	task automatic go_shift(input logic ir);
		logic q;
		tick(1'b1, ~tdi_o, q);
		if (ir) tick(1'b1, ~tdi_o, q);
		tick(1'b0, ~tdi_o, q);
		tick(1'b0, ~tdi_o, q);
	endtask
	// Least significant bit first both ways
	task automatic bits(input int n, input logic [31:0] din, input logic last, output logic [31:0] dout);
		logic q;
		dout = '0;
		for (int k = 0; k < n; k++) begin
			tick((k == n - 1) ? last : 1'b0, din[k], q);
			dout[k] = q;
		end
	endtask
	task automatic leave();
		logic q;
		tick(1'b1, ~tdi_o, q);
		tick(1'b0, ~tdi_o, q);
	endtask
	task automatic idle(input int n);
		logic q;
		repeat (n) tick(1'b0, ~tdi_o, q);
	endtask
	task automatic ir(input logic [3:0] code, output logic [3:0] cap);
		logic [31:0] o;
		go_shift(1'b1);
		bits(4, {28'h0, code}, 1'b1, o);
		cap = o[3:0];
		leave();
	endtask
	task automatic dr(input int n, input logic [31:0] din, output logic [31:0] dout);
		go_shift(1'b0);
		bits(n, din, 1'b1, dout);
		leave();
	endtask
endmodule

// >>> tb/test_jpd_top.sv
// Self-checking bench for the scan-port programming data path
`timescale 1ns/1ns
module test_jpd_top;
	import jpd_pkg::*;
	localparam int RTO = 12;
	localparam int PB = PAGE_BYTES_DEF;
	logic clk_i, sys_rst_i, fuse, ext_rst_n, tck, tms, tdi, tdo, tdo_oe, re, we, apply, exec, core_rst, prog;
	logic [CMD_W-1:0] cmd_res, cmd;
	logic [7:0] addr, wdata, rdata, praddr, prdata;
	logic [31:0] o;
	logic [3:0] cap;
	int err_count, compares, apply_cnt, exec_cnt, e;
	jpd_top #(.PAGE_BYTES(PB), .RESET_TIMEOUT_CYC(RTO)) u_dut (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .tck_i(tck),
		.tms_i(tms), .tdi_i(tdi), .tdo_o(tdo), .tdo_oe_o(tdo_oe), .scan_port_enable_fuse_i(fuse),
		.ext_reset_n_i(ext_rst_n), .cmd_result_i(cmd_res), .cmd_o(cmd), .cmd_apply_o(apply), .cmd_exec_o(exec),
		.core_reset_o(core_rst), .prog_mode_o(prog), .page_raddr_i(praddr), .page_rdata_o(prdata),
		.reg_addr_i(addr), .reg_wdata_i(wdata), .reg_we_i(we), .reg_re_i(re), .reg_rdata_o(rdata));
	jpd_prog_model u_prog (.clk_i(clk_i), .tdo_i(tdo), .tck_o(tck), .tms_o(tms), .tdi_o(tdi));
	// ------------------------------------------------------------
	// Tasks
	// ------------------------------------------------------------
	task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
		compares++;
		if (got !== exp) begin
			err_count++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_i);
		addr <= a;
		wdata <= d;
		we <= 1'b1;
		@(posedge clk_i);
		we <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] exp, input logic [7:0] m);
		@(posedge clk_i);
		addr <= a;
		re <= 1'b1;
		@(posedge clk_i);
		re <= 1'b0;
		@(posedge clk_i);
		check("reg_rdata", 32'(exp), 32'(rdata & m));
	endtask
	task automatic wrap_up();
		if (err_count == 0 && compares > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	// ------------------------------------------------------------
	// Clock, pulse counters, watchdog
	// ------------------------------------------------------------
	initial begin
		clk_i = 1'b0;
		forever #50 clk_i = ~clk_i;
	end
	always @(posedge clk_i) begin
		if (apply === 1'b1) apply_cnt++;
		if (exec === 1'b1) exec_cnt++;
	end
	initial begin
		repeat (80000) @(posedge clk_i);
		err_count++;
		wrap_up();
	end
	initial begin
		{sys_rst_i, fuse, ext_rst_n} = 3'b111;
		{re, we, cmd_res, addr, wdata, praddr} = '0;
		{err_count, compares, apply_cnt, exec_cnt} = '0;
		repeat (10) @(posedge clk_i);
		sys_rst_i <= 1'b0;
		repeat (4) @(posedge clk_i);
		rd(STAT_ADDR, 8'hf8, 8'hff);
		rd(8'h7e, 8'h00, 8'hff);
		u_prog.start();
		// Core goes through the reset chain before unlocking
		u_prog.ir(IR_HOLD_RESET, cap);
		check("ir_capture", 32'(IR_CAPTURE_VAL), 32'(cap));
		u_prog.go_shift(1'b0);
		u_prog.bits(1, 32'h1, 1'b1, o);
		repeat (2) @(posedge clk_i);
		check("core_reset_on", 32'h1, 32'(core_rst));
		u_prog.leave();
		u_prog.go_shift(1'b0);
		repeat (4) @(posedge clk_i);
		check("tdo_enable", 32'h1, 32'(tdo_oe));
		u_prog.bits(1, 32'h0, 1'b1, o);
		check("reset_chain", 32'h1, o);
		repeat (RTO - 4) @(posedge clk_i);
		check("core_reset_hold", 32'h1, 32'(core_rst));
		repeat (10) @(posedge clk_i);
		check("core_reset_off", 32'h0, 32'(core_rst));
		u_prog.leave();
		rd(STAT_ADDR, 8'hc8, 8'hff);
		u_prog.ir(IR_UNLOCK, cap);
		u_prog.dr(16, 32'(UNLOCK_SIG ^ 16'h8000), o);
		check("prog_bad_sig", 32'h0, 32'(prog));
		u_prog.go_shift(1'b0);
		u_prog.bits(16, 32'(UNLOCK_SIG), 1'b1, o);
		repeat (2) @(posedge clk_i);
		check("prog_before_update", 32'h0, 32'(prog));
		u_prog.leave();
		check("prog_mode", 32'h1, 32'(prog));
		cmd_res <= 15'h2a5c;
		u_prog.ir(IR_COMMAND, cap);
		u_prog.dr(15, 32'({OP_LOAD_DATA_HI, 8'h11}), o);
		check("cmd_capture", 32'h2a5c, o);
		check("apply_refused", 32'h0, 32'(apply_cnt));
		rd(STAT_ADDR, 8'h5d, 8'hff);
		wr(STAT_ADDR, 8'h04);
		rd(STAT_ADDR, 8'h59, 8'hff);
		u_prog.dr(15, 32'({OP_LOAD_DATA_LO, 8'h22}), o);
		check("cmd_lo", 32'({OP_LOAD_DATA_LO, 8'h22}), 32'(cmd));
		u_prog.dr(15, 32'({OP_LOAD_DATA_HI, 8'h33}), o);
		check("cmd_hi", 32'({OP_LOAD_DATA_HI, 8'h33}), 32'(cmd));
		repeat (2) @(posedge clk_i);
		check("apply_count", 32'h2, 32'(apply_cnt));
		e = exec_cnt;
		u_prog.idle(3);
		repeat (2) @(posedge clk_i);
		check("exec_count", 32'(e + 3), 32'(exec_cnt));
		u_prog.ir(IR_PAGE_LOAD, cap);
		u_prog.go_shift(1'b0);
		for (int i = 0; i < PB; i++) begin
			u_prog.bits(8, 32'(8'(i) ^ 8'ha5), i == PB - 1, o);
		end
		u_prog.leave();
		for (int i = 0; i < PB; i++) begin
			@(posedge clk_i);
			praddr <= 8'(i);
			repeat (2) @(posedge clk_i);
			check("page_rdata", 32'(8'(i) ^ 8'ha5), 32'(prdata));
		end
		// Input held high while reading: it must not reach the output
		u_prog.ir(IR_PAGE_READ, cap);
		u_prog.go_shift(1'b0);
		u_prog.bits(8, 32'hff, 1'b0, o);
		check("read_lead", 32'h0, o);
		for (int i = 0; i < PB; i++) begin
			u_prog.bits(8, 32'hff, i == PB - 1, o);
			check("read_byte", 32'(8'(i) ^ 8'ha5), o);
		end
		u_prog.leave();
		wr(CCSR_ADDR, 8'h80);
		repeat (4) @(posedge clk_i);
		rd(CCSR_ADDR, 8'h80, 8'hff);
		rd(STAT_ADDR, 8'h00, 8'h08);
		ext_rst_n <= 1'b0;
		repeat (8) @(posedge clk_i);
		rd(CCSR_ADDR, 8'h00, 8'hff);
		ext_rst_n <= 1'b1;
		fuse <= 1'b0;
		repeat (6) @(posedge clk_i);
		rd(STAT_ADDR, 8'h00, 8'h08);
		u_prog.ir(IR_COMMAND, cap);
		u_prog.go_shift(1'b1);
		repeat (4) @(posedge clk_i);
		check("tdo_enable_blocked", 32'h0, 32'(tdo_oe));
		fuse <= 1'b1;
		sys_rst_i <= 1'b1;
		repeat (2) @(posedge clk_i);
		sys_rst_i <= 1'b0;
		repeat (6) @(posedge clk_i);
		check("prog_after_reset", 32'h0, 32'(prog));
		// System reset loads the unlock chain with zero, so only zeros shift out of it
		u_prog.start();
		u_prog.ir(IR_UNLOCK, cap);
		u_prog.dr(16, 32'h0, o);
		check("unlock_after_reset", 32'h0, o);
		wrap_up();
	end
endmodule
